// ### design/sscl_pkg.sv
// Summary of operation
// - Device unconfigured after power-up until loaded.
// - Host takes bytes written by software, serializes onto data line.
// - Program line low throughout load, monitored.
// - Reset and program low together clear; rising edge samples mode.
// - Reset after configuration resets user registers.
// - Host waits for memory clear before shifting.
// - Mode bits 0,1 high; bit 2 pulled.
// - Device captures one bit per rising clock edge.
// - Data line becomes user input after load.
// - Device ignores data and clock after load.
// - Clock low, set data, then clock high.
// - Host sends whole image, then stops.
package sscl_pkg;
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam int LEN_W = 16;

   localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
   localparam logic [APB_AW-1:0] STAT_OFS = 8'h04;
   localparam logic [APB_AW-1:0] DATA_OFS = 8'h08;
   localparam logic [APB_AW-1:0] LEN_OFS = 8'h0c;

   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_URST_BIT = 1;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_BREQ_BIT = 2;
   localparam int ST_PROG_BIT = 3;

   localparam logic [2:0] SLAVE_SERIAL_MODE = 3'h7;
   localparam logic [2:0] BIT_LAST = 3'h7;

   localparam logic [LEN_W-1:0] CLR_CYCLES_MIN = 16'h00a0;
   localparam logic [LEN_W-1:0] CLR_CYCLES_MAX = 16'h00c5;
   localparam logic [LEN_W-1:0] SYNC_MARGIN = 16'h0008;
   localparam logic [LEN_W-1:0] HOLD_CYCLES = 16'h0004;
   localparam logic [LEN_W-1:0] HALF_BIT_CYCLES = 16'h0002;
   localparam logic [LEN_W-1:0] IMAGE_BYTES_DFLT = 16'h05e2;
endpackage

// ### design/sscl_link_if.sv
`timescale 1ns/1ps
interface sscl_link_if;
   logic cfg_data;
   logic config_shift_clock;
   logic reset_n;
   logic mode_select_bit0;
   logic mode_select_bit1;
   logic mode_select_bit2;
   logic prog_host_o;
   logic prog_host_oe;
   logic prog_dev_o;
   logic prog_dev_oe;
   logic load_complete_program;

   // Left floating at the board, internal pull-up
   assign mode_select_bit2 = 1'b1;
   // Open-drain wire with pull-up
   assign load_complete_program = (prog_host_oe ? prog_host_o : 1'b1) &
                                  (prog_dev_oe ? prog_dev_o : 1'b1);

   modport host (
      output cfg_data,
      output config_shift_clock,
      output reset_n,
      output mode_select_bit0,
      output mode_select_bit1,
      output prog_host_o,
      output prog_host_oe,
      input load_complete_program
   );

   modport device (
      input cfg_data,
      input config_shift_clock,
      input reset_n,
      input mode_select_bit0,
      input mode_select_bit1,
      input mode_select_bit2,
      output prog_dev_o,
      output prog_dev_oe,
      input load_complete_program
   );
endinterface

// ### design/sscl_sync.sv
`timescale 1ns/1ps
module sscl_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule

// ### design/sscl_device.sv
`timescale 1ns/1ps
module sscl_device import sscl_pkg::*; #(
   parameter logic [LEN_W-1:0] IMAGE_BYTES = IMAGE_BYTES_DFLT,
   parameter logic [LEN_W-1:0] CLR_CYCLES = CLR_CYCLES_MAX
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   sscl_link_if.device LINK,
   output logic CONFIGURED,
   output logic USER_RST,
   output logic USER_IO_IN,
   output logic [2:0] MODE_SEL,
   output logic [7:0] IMAGE_SUM
);
   typedef enum logic [2:0] {DV_UNCONF, DV_CLEAR, DV_LOAD, DV_USER, DV_HALT} sscl_dev_e;

   localparam logic [LEN_W+2:0] LAST_BIT = {IMAGE_BYTES, 3'h0} - 19'h1;

   sscl_dev_e state_ff;
   logic [LEN_W-1:0] tmr_ff;
   logic rst_q_ff, rst_seen_ff, clear_ff;
   logic [2:0] mode_ff;
   logic [6:0] pins_s;
   logic prog_s, rstn_s, din_s, done_s, start, clr_done;
   logic [2:0] mode_s;
   logic [LEN_W+2:0] cnt_lk_ff;
   logic [7:0] sr_lk_ff, sum_lk_ff;
   logic done_lk_ff;
   logic [7:0] nxt_byte;

   sscl_sync #(.W(7), .RST_VAL(7'h7c)) u_sync (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .d({LINK.load_complete_program, LINK.reset_n, LINK.mode_select_bit2,
          LINK.mode_select_bit1, LINK.mode_select_bit0, LINK.cfg_data, done_lk_ff}),
      .q(pins_s)
   );
   assign {prog_s, rstn_s, mode_s, din_s, done_s} = pins_s;
   assign start = !prog_s && !rstn_s;
   assign clr_done = (tmr_ff == CLR_CYCLES - 16'h1);

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_ff <= DV_UNCONF;
         tmr_ff <= '0;
      end else begin
         unique case (state_ff)
            DV_UNCONF, DV_USER, DV_HALT: begin
               tmr_ff <= '0;
               if (start) state_ff <= DV_CLEAR;
            end
            DV_CLEAR: begin
               if (!clr_done) tmr_ff <= tmr_ff + 16'h1;
               else if (rst_seen_ff) begin
                  state_ff <= (mode_ff == SLAVE_SERIAL_MODE) ? DV_LOAD : DV_HALT;
               end
            end
            DV_LOAD: begin
               tmr_ff <= '0;
               // A new program pulse aborts a load in progress
               if (start) state_ff <= DV_CLEAR;
               else if (done_s) state_ff <= DV_USER;
            end
         endcase
      end
   end

   // Mode is latched on the reset rise seen during or after the clear
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rst_q_ff <= 1'b1;
         rst_seen_ff <= 1'b0;
         mode_ff <= '0;
      end else begin
         rst_q_ff <= rstn_s;
         if (state_ff != DV_CLEAR) rst_seen_ff <= 1'b0;
         if (rstn_s && !rst_q_ff && state_ff == DV_CLEAR) begin
            rst_seen_ff <= 1'b1;
            mode_ff <= mode_s;
         end
      end
   end

   // Link side held cleared while unconfigured, during the clear and on a start; not in user or halt
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         clear_ff <= 1'b1;
      end else begin
         clear_ff <= (state_ff == DV_CLEAR) || (state_ff == DV_UNCONF) || start;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         LINK.prog_dev_o <= 1'b0;
         LINK.prog_dev_oe <= 1'b0;
      end else begin
         LINK.prog_dev_o <= 1'b0;
         // Hold program low until the image is in
         LINK.prog_dev_oe <= (state_ff == DV_CLEAR) || (state_ff == DV_LOAD) ||
                             (state_ff == DV_HALT) || start;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         CONFIGURED <= 1'b0;
         USER_RST <= 1'b1;
         USER_IO_IN <= 1'b0;
         MODE_SEL <= '0;
         IMAGE_SUM <= '0;
      end else begin
         CONFIGURED <= (state_ff == DV_USER);
         USER_RST <= (state_ff != DV_USER) || !rstn_s;
         USER_IO_IN <= (state_ff == DV_USER) && din_s;
         MODE_SEL <= mode_ff;
         // Sum is static once done has crossed
         if (state_ff == DV_LOAD && done_s) IMAGE_SUM <= sum_lk_ff;
      end
   end

   assign nxt_byte = {LINK.cfg_data, sr_lk_ff[7:1]};

   always_ff @(posedge LINK.config_shift_clock or posedge clear_ff) begin
      if (clear_ff) begin
         cnt_lk_ff <= '0;
         sr_lk_ff <= '0;
         sum_lk_ff <= '0;
         done_lk_ff <= 1'b0;
      end else if (!done_lk_ff) begin
         sr_lk_ff <= nxt_byte;
         cnt_lk_ff <= cnt_lk_ff + 19'h1;
         if (cnt_lk_ff[2:0] == BIT_LAST) sum_lk_ff <= sum_lk_ff ^ nxt_byte;
         if (cnt_lk_ff == LAST_BIT) done_lk_ff <= 1'b1;
      end
   end
endmodule

// ### design/sscl_host.sv
`timescale 1ns/1ps
module sscl_host import sscl_pkg::*; #(
   parameter logic [LEN_W-1:0] CLR_WAIT = CLR_CYCLES_MAX + SYNC_MARGIN,
   parameter logic [LEN_W-1:0] HALF_BIT = HALF_BIT_CYCLES,
   parameter logic [LEN_W-1:0] DFLT_LEN = IMAGE_BYTES_DFLT
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [APB_AW-1:0] PADDR,
   input wire logic [APB_DW-1:0] PWDATA,
   output logic [APB_DW-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   sscl_link_if.host LINK
);
   typedef enum logic [2:0] {
      H_IDLE, H_PROG, H_CLEAR, H_BYTE, H_LOW, H_HIGH, H_WAIT, H_DONE
   } sscl_host_e;

   sscl_host_e state_ff;
   logic [LEN_W-1:0] tmr_ff;
   logic [LEN_W-1:0] cnt_ff;
   logic [LEN_W-1:0] len_ff;
   logic [7:0] sr_ff;
   logic [2:0] bit_ff;
   logic [7:0] byte_ff;
   logic bvld_ff;
   logic urst_ff;
   logic done_ff;
   logic prog_s;
   logic acc, stall, commit, wr, start;

   function automatic logic sscl_mapped(input logic [APB_AW-1:0] a);
      sscl_mapped = (a == CTRL_OFS) || (a == STAT_OFS) ||
                    (a == DATA_OFS) || (a == LEN_OFS);
   endfunction

   sscl_sync #(.W(1), .RST_VAL(1'b1)) u_prog_sync (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .d(LINK.load_complete_program),
      .q(prog_s)
   );

   assign acc = PSEL && PENABLE;
   // A byte write waits while the previous byte is not yet taken for shifting
   assign stall = PWRITE && (PADDR == DATA_OFS) && bvld_ff;
   assign commit = acc && PREADY;
   assign wr = commit && PWRITE && sscl_mapped(PADDR);
   assign start = wr && (PADDR == CTRL_OFS) && PWDATA[CTRL_START_BIT];

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= '0;
      end else begin
         PREADY <= acc && !PREADY && !stall;
         PSLVERR <= acc && !PREADY && !stall && !sscl_mapped(PADDR);
         PRDATA <= '0;
         if (acc && !PREADY && !PWRITE) begin
            unique case (PADDR)
               CTRL_OFS: PRDATA[CTRL_URST_BIT] <= urst_ff;
               STAT_OFS: begin
                  PRDATA[ST_BUSY_BIT] <= (state_ff != H_IDLE) && (state_ff != H_DONE);
                  PRDATA[ST_DONE_BIT] <= done_ff;
                  PRDATA[ST_BREQ_BIT] <= (state_ff == H_BYTE) && !bvld_ff;
                  PRDATA[ST_PROG_BIT] <= prog_s;
               end
               LEN_OFS: PRDATA[LEN_W-1:0] <= len_ff;
               default: PRDATA <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         len_ff <= DFLT_LEN;
         urst_ff <= 1'b0;
      end else if (wr) begin
         if (PADDR == LEN_OFS) len_ff <= PWDATA[LEN_W-1:0];
         if (PADDR == CTRL_OFS) urst_ff <= PWDATA[CTRL_URST_BIT];
      end
   end

   // Software feeds the image one byte per write
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         byte_ff <= '0;
         bvld_ff <= 1'b0;
      end else if (wr && PADDR == DATA_OFS) begin
         byte_ff <= PWDATA[7:0];
         bvld_ff <= 1'b1;
      end else if (state_ff == H_BYTE && bvld_ff) begin
         bvld_ff <= 1'b0;
      end
   end

   // Mode straps are fixed for slave serial loading
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         LINK.mode_select_bit0 <= 1'b1;
         LINK.mode_select_bit1 <= 1'b1;
         LINK.prog_host_o <= 1'b0;
      end else begin
         LINK.mode_select_bit0 <= 1'b1;
         LINK.mode_select_bit1 <= 1'b1;
         LINK.prog_host_o <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_ff <= H_IDLE;
         tmr_ff <= '0;
         cnt_ff <= '0;
         sr_ff <= '0;
         bit_ff <= '0;
         done_ff <= 1'b0;
         LINK.config_shift_clock <= 1'b1;
         LINK.cfg_data <= 1'b0;
         LINK.reset_n <= 1'b1;
         LINK.prog_host_oe <= 1'b0;
      end else begin
         unique case (state_ff)
            H_IDLE, H_DONE: begin
               LINK.reset_n <= !urst_ff;
               if (start) begin
                  state_ff <= H_PROG;
                  tmr_ff <= '0;
                  done_ff <= 1'b0;
                  LINK.prog_host_oe <= 1'b1;
                  LINK.reset_n <= 1'b0;
               end
            end
            H_PROG: begin
               tmr_ff <= tmr_ff + 16'h1;
               if (tmr_ff == HOLD_CYCLES - 16'h1) begin
                  // Device keeps the line low from here on
                  LINK.prog_host_oe <= 1'b0;
                  LINK.reset_n <= 1'b1;
                  tmr_ff <= '0;
                  state_ff <= H_CLEAR;
               end
            end
            H_CLEAR: begin
               tmr_ff <= tmr_ff + 16'h1;
               if (tmr_ff == CLR_WAIT - 16'h1) begin
                  tmr_ff <= '0;
                  cnt_ff <= '0;
                  state_ff <= H_BYTE;
               end
            end
            H_BYTE: begin
               if (bvld_ff) begin
                  sr_ff <= byte_ff;
                  bit_ff <= '0;
                  tmr_ff <= '0;
                  LINK.config_shift_clock <= 1'b0;
                  LINK.cfg_data <= byte_ff[0];
                  state_ff <= H_LOW;
               end
            end
            H_LOW: begin
               tmr_ff <= tmr_ff + 16'h1;
               if (tmr_ff == HALF_BIT - 16'h1) begin
                  tmr_ff <= '0;
                  LINK.config_shift_clock <= 1'b1;
                  state_ff <= H_HIGH;
               end
            end
            H_HIGH: begin
               tmr_ff <= tmr_ff + 16'h1;
               if (tmr_ff == HALF_BIT - 16'h1) begin
                  tmr_ff <= '0;
                  if (bit_ff == BIT_LAST) begin
                     cnt_ff <= cnt_ff + 16'h1;
                     // Stop at the image end
                     state_ff <= (cnt_ff == len_ff - 16'h1) ? H_WAIT : H_BYTE;
                  end else begin
                     bit_ff <= bit_ff + 3'h1;
                     sr_ff <= {1'b0, sr_ff[7:1]};
                     LINK.config_shift_clock <= 1'b0;
                     LINK.cfg_data <= sr_ff[1];
                     state_ff <= H_LOW;
                  end
               end
            end
            H_WAIT: begin
               // No timeout: a bad image leaves the block busy
               if (prog_s) begin
                  done_ff <= 1'b1;
                  state_ff <= H_DONE;
               end
            end
         endcase
      end
   end
endmodule

// ### tb/sscl_monitor.sv
`timescale 1ns/1ps
module sscl_monitor (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic cfg_data,
   input wire logic config_shift_clock,
   input wire logic reset_n,
   input wire logic mode_select_bit0,
   input wire logic mode_select_bit1,
   input wire logic prog_host_oe,
   input wire logic prog_dev_oe,
   input wire logic load_complete_program
);
   default clocking mon_cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);

   a_prog_with_reset: assert property ($rose(prog_host_oe) |-> $fell(reset_n))
      else $error("program pull not paired with reset");
   a_pulse_four: assert property ($rose(prog_host_oe) |-> prog_host_oe[*4] ##1 !prog_host_oe)
      else $error("program pulse length wrong");
   a_device_takes_over: assert property ($fell(prog_host_oe) |-> prog_dev_oe)
      else $error("program line released before load");
   a_quiet_clear: assert property ($fell(prog_host_oe) |-> config_shift_clock[*8])
      else $error("shift clock moved during clear");
   a_modes_high: assert property (mode_select_bit0 && mode_select_bit1)
      else $error("mode pins not high");
   a_low_half: assert property ($fell(config_shift_clock) |->
      !config_shift_clock[*2] ##1 config_shift_clock)
      else $error("shift clock low phase wrong");
   a_data_steady: assert property ($fell(config_shift_clock) |=> $stable(cfg_data)[*2])
      else $error("data moved while clock low");
   a_idle_clock: assert property (load_complete_program |-> config_shift_clock)
      else $error("shift clock low outside load");
   a_edge_in_load: assert property ($rose(config_shift_clock) |-> prog_dev_oe)
      else $error("bit shifted while device idle");

   c_start: cover property ($rose(prog_host_oe));
   c_done: cover property ($rose(load_complete_program));
   c_user_reset: cover property ($fell(reset_n) && !prog_host_oe);
endmodule

// ### tb/slave_serial_config_loader_test.sv
`timescale 1ns/1ps
module slave_serial_config_loader_test;
   import sscl_pkg::*;
   logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic d1_cfg, d1_urst, d1_io, d2_cfg, d2_urst, d2_io;
   logic [2:0] d1_mode, d2_mode;
   logic [7:0] d1_sum, d2_sum;
   logic [7:0] img [4] = '{8'ha5, 8'h3c, 8'h01, 8'h06};
   logic wire_bits [$];
   int fail_count = 0;
   int num_checks = 0;

   sscl_link_if link_a ();
   sscl_link_if link_b ();

   sscl_host #(.CLR_WAIT(16'h0028)) sscl_host_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link_a));
   sscl_device #(.IMAGE_BYTES(16'h0004), .CLR_CYCLES(16'h0020)) sscl_device_inst (
      .REF_CLK(ref_clk), .SYS_RST(sys_rst), .LINK(link_a), .CONFIGURED(d1_cfg),
      .USER_RST(d1_urst), .USER_IO_IN(d1_io), .MODE_SEL(d1_mode), .IMAGE_SUM(d1_sum));
   // Second device faces the bench, so host-side faults can be staged
   sscl_device #(.IMAGE_BYTES(16'h0004), .CLR_CYCLES(16'h0020)) sscl_device_inst_b (
      .REF_CLK(ref_clk), .SYS_RST(sys_rst), .LINK(link_b), .CONFIGURED(d2_cfg),
      .USER_RST(d2_urst), .USER_IO_IN(d2_io), .MODE_SEL(d2_mode), .IMAGE_SUM(d2_sum));
   sscl_monitor sscl_monitor_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
      .cfg_data(link_a.cfg_data), .config_shift_clock(link_a.config_shift_clock),
      .reset_n(link_a.reset_n), .mode_select_bit0(link_a.mode_select_bit0),
      .mode_select_bit1(link_a.mode_select_bit1), .prog_host_oe(link_a.prog_host_oe),
      .prog_dev_oe(link_a.prog_dev_oe), .load_complete_program(link_a.load_complete_program));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Bits as the device sees them on the wire
   always @(posedge link_a.config_shift_clock) begin
      if (sys_rst === 1'b0) begin
         wire_bits.push_back(link_a.cfg_data);
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Stalled data writes hold the access phase until the byte is taken
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      // Only the watchdog ends a wait; values read here stood up to this edge
      while (pready !== 1'b1) begin
         @(posedge ref_clk);
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic b_byte(input logic [7:0] b);
      for (int k = 0; k < 8; k++) begin
         link_b.config_shift_clock <= 1'b0;
         link_b.cfg_data <= b[k];
         #3;
         link_b.config_shift_clock <= 1'b1;
         #3;
      end
   endtask

   task automatic b_load(input logic m0);
      @(posedge ref_clk);
      link_b.mode_select_bit0 <= m0;
      link_b.reset_n <= 1'b0;
      link_b.prog_host_oe <= 1'b1;
      repeat (4) @(posedge ref_clk);
      link_b.reset_n <= 1'b1;
      link_b.prog_host_oe <= 1'b0;
      repeat (45) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         b_byte(img[i]);
      end
      repeat (20) @(posedge ref_clk);
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      wrap_up();
   end

   initial begin
      sys_rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      link_b.cfg_data = 1'b0;
      link_b.config_shift_clock = 1'b1;
      link_b.reset_n = 1'b1;
      link_b.mode_select_bit0 = 1'b1;
      link_b.mode_select_bit1 = 1'b1;
      link_b.prog_host_o = 1'b0;
      link_b.prog_host_oe = 1'b0;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      check("unconfigured", d1_cfg, 1'b0);
      apb(0, LEN_OFS, 32'h0);
      check("len default", rdata, {16'h0, IMAGE_BYTES_DFLT});
      apb(0, STAT_OFS, 32'h0);
      check("idle status", rdata, 32'h8);
      apb(0, 8'h10, 32'h0);
      check("unmapped err", rerr, 1'b1);
      check("unmapped data", rdata, 32'h0);
      apb(1, LEN_OFS, 32'h4);
      apb(1, CTRL_OFS, 32'h1);
      apb(0, STAT_OFS, 32'h0);
      check("busy", rdata[0], 1'b1);
      rdata = '0;
      for (int i = 0; i < 100 && rdata[ST_BREQ_BIT] !== 1'b1; i++) begin
         apb(0, STAT_OFS, 32'h0);
      end
      check("byte request", rdata, 32'h5);
      for (int i = 0; i < 4; i++) begin
         apb(1, DATA_OFS, {24'h0, img[i]});
      end
      rdata = '0;
      for (int i = 0; i < 100 && rdata[ST_DONE_BIT] !== 1'b1; i++) begin
         apb(0, STAT_OFS, 32'h0);
      end
      check("done status", rdata, 32'ha);
      check("bit count", wire_bits.size(), 32);
      for (int i = 0; i < 32; i++) begin
         check("wire bit", wire_bits[i], img[i / 8][i % 8]);
      end
      check("configured", d1_cfg, 1'b1);
      check("image sum", d1_sum, 8'h9e);
      check("mode", d1_mode, SLAVE_SERIAL_MODE);
      check("line released", link_a.load_complete_program, 1'b1);
      check("user io", d1_io, img[3][7]);
      check("user run", d1_urst, 1'b0);
      apb(1, CTRL_OFS, 32'h2);
      repeat (6) @(posedge ref_clk);
      check("user reset", d1_urst, 1'b1);
      check("kept config", d1_cfg, 1'b1);
      apb(0, CTRL_OFS, 32'h0);
      check("ctrl level", rdata, 32'h2);
      apb(1, CTRL_OFS, 32'h0);
      repeat (6) @(posedge ref_clk);
      check("user released", d1_urst, 1'b0);
      b_load(1'b1);
      check("b configured", d2_cfg, 1'b1);
      check("b sum", d2_sum, 8'h9e);
      b_byte(8'hff);
      repeat (6) @(posedge ref_clk);
      check("b ignores link", d2_sum, 8'h9e);
      check("b still up", d2_cfg, 1'b1);
      check("b io high", d2_io, 1'b1);
      link_b.cfg_data <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check("b io low", d2_io, 1'b0);
      b_load(1'b0);
      check("b wrong mode", d2_mode, 3'h6);
      check("b not loaded", d2_cfg, 1'b0);
      check("b line held", link_b.load_complete_program, 1'b0);
      wrap_up();
   end
endmodule
